// [core/icu_pkg.sv]
// constants and types shared by the internal clock unit
package icu_pkg;

   // ************************************************************
   // register offsets on the plain register port
   // ************************************************************
   localparam logic [1:0] ADDR_SOURCE_CONTROL = 2'h0;
   localparam logic [1:0] ADDR_DIVIDER_CONTROL = 2'h1;
   localparam logic [1:0] ADDR_PERIOD_ADJUST = 2'h2;
   localparam logic [1:0] ADDR_STATUS_FINE_ADJUST = 2'h3;

   // ************************************************************
   // field positions
   // ************************************************************
   localparam int SRC_SEL_BIT = 6;
   localparam int REF_KEEP_BIT = 0;
   localparam int DIV_MSB = 7;
   localparam int DIV_LSB = 6;
   localparam int LOOP_OFF_BIT = 3;
   localparam int STATUS_BIT = 2;
   localparam int FINE_BIT = 0;

   // ************************************************************
   // values after reset
   // ************************************************************
   localparam logic SRC_SEL_RESET = 1'b0;
   localparam logic REF_KEEP_RESET = 1'b0;
   localparam logic [1:0] DIV_RESET = 2'h1;
   localparam logic LOOP_OFF_RESET = 1'b0;
   localparam logic [7:0] TRIM_POR = 8'h80;
   localparam logic FINE_POR = 1'b0;

   // ************************************************************
   // oscillator model constants, reference base period in cycles of clk
   // ************************************************************
   localparam logic [11:0] REF_BASE_CYCLES = 12'h600;
   localparam logic [9:0] LOOP_MULT = 10'h200;
   localparam logic [15:0] NCO_INC_RESET = 16'h4000;
   localparam int LOOP_GAIN_SHIFT = 5;

   // ************************************************************
   // operating modes
   // ************************************************************
   typedef enum logic [1:0] {
      MODE_LOOP_ENGAGED,
      MODE_LOOP_BYPASSED,
      MODE_BYPASS_LOW_POWER,
      MODE_STOP
   } icu_mode_type;

endpackage : icu_pkg

// [core/icu_ref_osc.sv]
// trimmable internal reference oscillator, modelled as a tick train
`timescale 1ns/1ps
`default_nettype none
module icu_ref_osc (
   input wire logic clk,
   input wire logic reset,
   input wire logic enable,
   input wire logic [8:0] trim9,
   output logic tick
);

   typedef struct packed {
      logic [11:0] cnt;
      logic tick;
   } icu_ref_state_type;

   icu_ref_state_type s_reg;
   icu_ref_state_type s_next;
   logic [11:0] period;

   // larger trim gives a longer period, fine bit is the lsb
   assign period = icu_pkg::REF_BASE_CYCLES + {3'h0, trim9};

   // ************************************************************
   // period counter
   // ************************************************************
   always_comb begin
      s_next = s_reg;
      s_next.tick = 1'b0;
      if (!enable) begin
         s_next.cnt = 12'h000;
      end else if (s_reg.cnt >= period - 12'h001) begin
         s_next.cnt = 12'h000;
         s_next.tick = 1'b1;
      end else begin
         s_next.cnt = s_reg.cnt + 12'h001;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign tick = s_reg.tick;

endmodule : icu_ref_osc
`default_nettype wire

// [core/icu_fll.sv]
// frequency-locked loop: nco locked to a multiple of the reference ticks
`timescale 1ns/1ps
`default_nettype none
module icu_fll (
   input wire logic clk,
   input wire logic reset,
   input wire logic enable,
   input wire logic ref_tick,
   output logic dco_tick
);

   typedef struct packed {
      logic [15:0] acc;
      logic [15:0] inc;
      logic [9:0] cnt;
      logic tick;
   } icu_fll_state_type;

   icu_fll_state_type s_reg;
   icu_fll_state_type s_next;
   logic [16:0] sum;
   logic signed [11:0] err;
   logic signed [18:0] adj;

   // ************************************************************
   // nco and frequency comparison
   // ************************************************************
   always_comb begin
      s_next = s_reg;
      s_next.tick = 1'b0;
      sum = {1'b0, s_reg.acc} + {1'b0, s_reg.inc};
      err = $signed({2'b00, icu_pkg::LOOP_MULT}) - $signed({2'b00, s_reg.cnt});
      adj = $signed({3'b000, s_reg.inc}) + 19'(err <<< icu_pkg::LOOP_GAIN_SHIFT);
      if (enable) begin
         s_next.acc = sum[15:0];
         s_next.tick = sum[16];
         if (sum[16] && s_reg.cnt != 10'h3ff) begin
            s_next.cnt = s_reg.cnt + 10'h001;
         end
         // steer toward the multiple of the reference per period
         if (ref_tick) begin
            s_next.cnt = 10'h000;
            if (adj < 19'sd1) begin
               s_next.inc = 16'h0001;
            end else if (adj > 19'sd65535) begin
               s_next.inc = 16'hffff;
            end else begin
               s_next.inc = adj[15:0];
            end
         end
      end
   end

   // the acquired increment is held while the loop is off
   always_ff @(posedge clk) begin
      if (reset) begin
         s_reg <= '{acc: 16'h0000, inc: icu_pkg::NCO_INC_RESET, cnt: 10'h000, tick: 1'b0};
      end else begin
         s_reg <= s_next;
      end
   end

   assign dco_tick = s_reg.tick;

endmodule : icu_fll
`default_nettype wire

// [core/icu_clock_unit.sv]
// internal clock unit: registers, modes, source switch and bus divider
//
// Notes on behaviour
// - system clock from loop or reference
// - system clock runs at twice bus rate
// - loop locks to 512 times reference
// - reset brings up loop-engaged mode
// - bypassed mode keeps loop on, reference out
// - low-power bypass turns loop off
// - stop kills loop and clock, reference optional
// - source select bit 6 of source_control
// - ref_stop_keep bit 0 keeps reference in stop
// - divider bits 7:6 give 1,2,4,8, reset 01
// - loop_off_in_bypass bit 3 disables loop
// - coarse period trim, larger means longer
// - nine trim bits in all
// - fine_adjust bit 0 is the smallest step
// - source_status bit 2 lags source select
// - divider change takes effect at once
// - wake from stop enters the mode the control bits select
// - trims survive every reset except power-on
`timescale 1ns/1ps
`default_nettype none
module icu_clock_unit (
   input wire logic clk,
   input wire logic reset,
   input wire logic power_on_reset,
   input wire logic [1:0] address,
   input wire logic [7:0] write_data,
   input wire logic write_strobe,
   input wire logic read_strobe,
   output logic [7:0] read_data,
   input wire logic stop_entry,
   input wire logic stop_wake,
   output logic system_clock_out,
   output logic bus_clock_tick,
   output logic ref_clock_tick,
   output logic loop_enabled,
   output logic source_status,
   output icu_pkg::icu_mode_type mode
);

   // ************************************************************
   // state of the unit
   // ************************************************************
   typedef struct packed {
      logic source_select;
      logic ref_stop_keep;
      logic [1:0] bus_divider_select;
      logic loop_off_in_bypass;
      logic [7:0] period_adjust;
      logic fine_adjust;
      logic sel_meta;
      logic sel_sync;
      logic active_src;
      icu_pkg::icu_mode_type mode;
      logic [7:0] rdata;
      logic [2:0] div_cnt;
      logic sys_tick;
      logic bus_phase;
      logic bus_tick;
   } icu_state_type;

   icu_state_type s_reg;
   icu_state_type s_next;

   logic ref_tick;
   logic dco_tick;
   logic ref_enable;
   logic loop_enable;
   logic raw_tick;
   logic new_src_tick;
   logic [2:0] div_mask;
   icu_pkg::icu_mode_type run_mode;

   // ************************************************************
   // oscillators
   // ************************************************************

   // reference runs except in stop without the keep bit
   assign ref_enable = (s_reg.mode != icu_pkg::MODE_STOP) || s_reg.ref_stop_keep;

   // loop runs only in engaged and plain bypassed modes
   assign loop_enable = (s_reg.mode == icu_pkg::MODE_LOOP_ENGAGED)
      || (s_reg.mode == icu_pkg::MODE_LOOP_BYPASSED);

   icu_ref_osc u_ref_osc (
      .clk(clk),
      .reset(reset),
      .enable(ref_enable),
      .trim9({s_reg.period_adjust, s_reg.fine_adjust}),
      .tick(ref_tick)
   );

   icu_fll u_fll (
      .clk(clk),
      .reset(reset),
      .enable(loop_enable),
      .ref_tick(ref_tick),
      .dco_tick(dco_tick)
   );

   // ************************************************************
   // mode decode and source selection
   // ************************************************************

   // running mode follows the control bits
   always_comb begin
      if (!s_reg.source_select) begin
         run_mode = icu_pkg::MODE_LOOP_ENGAGED;
      end else if (s_reg.loop_off_in_bypass) begin
         run_mode = icu_pkg::MODE_BYPASS_LOW_POWER;
      end else begin
         run_mode = icu_pkg::MODE_LOOP_BYPASSED;
      end
   end

   // ticks of the source now in use, none in stop
   assign raw_tick = (s_reg.mode != icu_pkg::MODE_STOP)
      && (s_reg.active_src ? ref_tick : dco_tick);

   // tick of the source being switched to
   assign new_src_tick = s_reg.sel_sync ? ref_tick : dco_tick;

   // divider mask: 000, 001, 011, 111
   always_comb begin
      unique case (s_reg.bus_divider_select)
         2'h0: div_mask = 3'h0;
         2'h1: div_mask = 3'h1;
         2'h2: div_mask = 3'h3;
         2'h3: div_mask = 3'h7;
      endcase
   end

   // ************************************************************
   // next state
   // ************************************************************
   always_comb begin
      s_next = s_reg;
      s_next.rdata = 8'h00;
      s_next.sys_tick = 1'b0;
      s_next.bus_tick = 1'b0;

      // register writes, unused bits dropped
      if (write_strobe) begin
         unique case (address)
            icu_pkg::ADDR_SOURCE_CONTROL: begin
               s_next.source_select = write_data[icu_pkg::SRC_SEL_BIT];
               s_next.ref_stop_keep = write_data[icu_pkg::REF_KEEP_BIT];
            end
            icu_pkg::ADDR_DIVIDER_CONTROL: begin
               s_next.bus_divider_select =
                  write_data[icu_pkg::DIV_MSB:icu_pkg::DIV_LSB];
               s_next.loop_off_in_bypass = write_data[icu_pkg::LOOP_OFF_BIT];
            end
            icu_pkg::ADDR_PERIOD_ADJUST: begin
               s_next.period_adjust = write_data;
            end
            icu_pkg::ADDR_STATUS_FINE_ADJUST: begin
               s_next.fine_adjust = write_data[icu_pkg::FINE_BIT];
            end
         endcase
      end

      // register reads, data stand for one cycle
      if (read_strobe) begin
         unique case (address)
            icu_pkg::ADDR_SOURCE_CONTROL: begin
               s_next.rdata[icu_pkg::SRC_SEL_BIT] = s_reg.source_select;
               s_next.rdata[icu_pkg::REF_KEEP_BIT] = s_reg.ref_stop_keep;
            end
            icu_pkg::ADDR_DIVIDER_CONTROL: begin
               s_next.rdata[icu_pkg::DIV_MSB:icu_pkg::DIV_LSB] = s_reg.bus_divider_select;
               s_next.rdata[icu_pkg::LOOP_OFF_BIT] = s_reg.loop_off_in_bypass;
            end
            icu_pkg::ADDR_PERIOD_ADJUST: begin
               s_next.rdata = s_reg.period_adjust;
            end
            icu_pkg::ADDR_STATUS_FINE_ADJUST: begin
               s_next.rdata[icu_pkg::STATUS_BIT] = s_reg.active_src;
               s_next.rdata[icu_pkg::FINE_BIT] = s_reg.fine_adjust;
            end
         endcase
      end

      // select bit crosses into the switch logic through two stages
      s_next.sel_meta = s_reg.source_select;
      s_next.sel_sync = s_reg.sel_meta;

      // hand over only on an edge of the new source
      if (s_reg.sel_sync != s_reg.active_src && new_src_tick
            && s_reg.mode != icu_pkg::MODE_STOP) begin
         s_next.active_src = s_reg.sel_sync;
      end

      // stop entry, wake and normal mode tracking
      if (s_reg.mode == icu_pkg::MODE_STOP) begin
         if (stop_wake) begin
            s_next.mode = run_mode;
         end
      end else if (stop_entry) begin
         s_next.mode = icu_pkg::MODE_STOP;
      end else begin
         s_next.mode = run_mode;
      end

      // divider: mask taken live, so a new setting acts at once
      if (raw_tick) begin
         s_next.div_cnt = s_reg.div_cnt + 3'h1;
         s_next.sys_tick = ((s_reg.div_cnt & div_mask) == div_mask);
      end

      // bus clock is every second system tick
      if (s_reg.sys_tick) begin
         s_next.bus_phase = ~s_reg.bus_phase;
         s_next.bus_tick = s_reg.bus_phase;
      end
   end

   // ************************************************************
   // state register
   // ************************************************************

   // trims kept through reset, loaded only at power-on
   always_ff @(posedge clk) begin
      if (power_on_reset || reset) begin
         s_reg.source_select <= icu_pkg::SRC_SEL_RESET;
         s_reg.ref_stop_keep <= icu_pkg::REF_KEEP_RESET;
         s_reg.bus_divider_select <= icu_pkg::DIV_RESET;
         s_reg.loop_off_in_bypass <= icu_pkg::LOOP_OFF_RESET;
         s_reg.sel_meta <= icu_pkg::SRC_SEL_RESET;
         s_reg.sel_sync <= icu_pkg::SRC_SEL_RESET;
         s_reg.active_src <= icu_pkg::SRC_SEL_RESET;
         s_reg.mode <= icu_pkg::MODE_LOOP_ENGAGED;
         s_reg.rdata <= 8'h00;
         s_reg.div_cnt <= 3'h0;
         s_reg.sys_tick <= 1'b0;
         s_reg.bus_phase <= 1'b0;
         s_reg.bus_tick <= 1'b0;
         if (power_on_reset) begin
            s_reg.period_adjust <= icu_pkg::TRIM_POR;
            s_reg.fine_adjust <= icu_pkg::FINE_POR;
         end else begin
            s_reg.period_adjust <= s_reg.period_adjust;
            s_reg.fine_adjust <= s_reg.fine_adjust;
         end
      end else begin
         s_reg <= s_next;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   assign read_data = s_reg.rdata;
   assign system_clock_out = s_reg.sys_tick;
   assign bus_clock_tick = s_reg.bus_tick;
   assign ref_clock_tick = ref_tick;
   assign loop_enabled = loop_enable;
   assign source_status = s_reg.active_src;
   assign mode = s_reg.mode;

endmodule : icu_clock_unit
`default_nettype wire

// [sim/icu_chk.sv]
// concurrent checks on the clock unit ports
`timescale 1ns/1ps
`default_nettype none
module icu_chk (
   input wire logic clk,
   input wire logic reset,
   input wire logic power_on_reset,
   input wire logic [1:0] address,
   input wire logic [7:0] write_data,
   input wire logic write_strobe,
   input wire logic read_strobe,
   input wire logic [7:0] read_data,
   input wire logic stop_entry,
   input wire logic stop_wake,
   input wire logic system_clock_out,
   input wire logic bus_clock_tick,
   input wire logic ref_clock_tick,
   input wire logic loop_enabled,
   input wire logic source_status,
   input wire icu_pkg::icu_mode_type mode
);
   // ****************
   // port relations
   // ****************
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset || power_on_reset);
   // readable bits of each register
   function automatic logic [7:0] used(input logic [1:0] a);
      case (a)
         2'h0: used = 8'h41;
         2'h1: used = 8'hc8;
         2'h2: used = 8'hff;
         default: used = 8'h05;
      endcase
   endfunction : used
   a_read_idle: assert property (!$past(read_strobe) |-> read_data == 8'h00)
      else $error("read data not zero outside read");
   a_unused_zero: assert property ($past(read_strobe) |-> (read_data & ~used($past(address))) == 8'h00)
      else $error("unused bit reads one");
   a_status_read: assert property ($past(read_strobe) && $past(address) == 2'h3 |-> read_data[2] == $past(source_status))
      else $error("status bit differs from source in use");
   a_loop_mode: assert property (loop_enabled == (mode inside {icu_pkg::MODE_LOOP_ENGAGED, icu_pkg::MODE_LOOP_BYPASSED}))
      else $error("loop enable wrong for mode");
   a_stop_quiet: assert property ((mode == icu_pkg::MODE_STOP) [*3] |-> !system_clock_out && !bus_clock_tick)
      else $error("clock tick in stop");
   a_bus_half: assert property (bus_clock_tick |-> $past(system_clock_out))
      else $error("bus tick without system tick");
   a_reset_mode: assert property ($fell(reset) |-> mode == icu_pkg::MODE_LOOP_ENGAGED && !source_status)
      else $error("not engaged after reset");
   a_stop_entry: assert property (stop_entry && mode != icu_pkg::MODE_STOP |=> mode == icu_pkg::MODE_STOP)
      else $error("stop not entered");
   a_wake_resume: assert property (stop_wake && mode == icu_pkg::MODE_STOP |-> ##[1:2] mode != icu_pkg::MODE_STOP)
      else $error("stop not left on wake");
   a_status_lag: assert property (write_strobe && address == 2'h0 && write_data[6] && !source_status && mode == icu_pkg::MODE_LOOP_ENGAGED |=> !source_status [*3])
      else $error("status follows select too soon");
   a_ref_pulse: assert property (ref_clock_tick |=> !ref_clock_tick [*8])
      else $error("reference ticks too close");
   // main scenarios
   c_status_up: cover property ($rose(source_status));
   c_wake: cover property (mode == icu_pkg::MODE_STOP ##1 stop_wake);
   c_bus: cover property (bus_clock_tick);
endmodule : icu_chk
bind icu_clock_unit icu_chk i_icu_chk (.clk, .reset, .power_on_reset, .address, .write_data,
   .write_strobe, .read_strobe, .read_data, .stop_entry, .stop_wake, .system_clock_out,
   .bus_clock_tick, .ref_clock_tick, .loop_enabled, .source_status, .mode);
`default_nettype wire

// [sim/tb_top.sv]
// register-level bench for the internal clock unit
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   // ****************
   // stimulus and design
   // ****************
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic power_on_reset = 1'b1;
   logic [1:0] address = 2'h0;
   logic [7:0] write_data = 8'h00;
   logic write_strobe = 1'b0;
   logic read_strobe = 1'b0;
   logic stop_entry = 1'b0;
   logic stop_wake = 1'b0;
   logic [7:0] read_data;
   logic system_clock_out;
   logic bus_clock_tick;
   logic ref_clock_tick;
   logic loop_enabled;
   logic source_status;
   icu_pkg::icu_mode_type mode;
   int n_fail = 0;
   int cmp_count = 0;
   int n_sys;
   int n_bus;
   int n_ref;
   int n_cyc;
   logic [7:0] ones [4] = '{8'h41, 8'hc8, 8'hff, 8'h01};
   logic [8:0] trims [3] = '{9'h067, 9'h066, 9'h000};
   // 100 ns clock
   always #50 clk = ~clk;
   icu_clock_unit i_icu_clock_unit (.clk, .reset, .power_on_reset, .address, .write_data,
      .write_strobe, .read_strobe, .read_data, .stop_entry, .stop_wake, .system_clock_out,
      .bus_clock_tick, .ref_clock_tick, .loop_enabled, .source_status, .mode);
   // ****************
   // tasks
   // ****************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH %0t got %0h expected %0h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk);
      address <= a;
      write_data <= d;
      write_strobe <= 1'b1;
      @(posedge clk);
      write_strobe <= 1'b0;
   endtask : wr
   task automatic rd(input logic [1:0] a, input logic [7:0] e);
      @(posedge clk);
      address <= a;
      read_strobe <= 1'b1;
      @(posedge clk);
      read_strobe <= 1'b0;
      #1 chk(read_data, e);
   endtask : rd
   // one-cycle stop entry or wake pulse
   task automatic pulse(input logic wake);
      @(posedge clk);
      stop_wake <= wake;
      stop_entry <= !wake;
      @(posedge clk);
      stop_wake <= 1'b0;
      stop_entry <= 1'b0;
      @(posedge clk);
      #1;
   endtask : pulse
   task automatic do_reset();
      @(posedge clk);
      reset <= 1'b1;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
   endtask : do_reset
   // count ticks until refs reference ticks or a cycle limit
   task automatic count(input int refs, input int cycles);
      n_sys = 0;
      n_bus = 0;
      n_ref = 0;
      n_cyc = 0;
      while (n_ref < refs && n_cyc < cycles) begin
         @(posedge clk);
         #1;
         n_cyc++;
         n_sys += system_clock_out;
         n_bus += bus_clock_tick;
         n_ref += ref_clock_tick;
      end
   endtask : count
   task automatic wait_status();
      for (int i = 0; i < 4000 && source_status !== 1'b1; i++) @(posedge clk);
   endtask : wait_status
   task automatic conclude();
      if (n_fail == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : conclude
   // ****************
   // tests
   // ****************
   initial begin
      repeat (12) @(posedge clk);
      reset <= 1'b0;
      power_on_reset <= 1'b0;
      rd(2'h0, 8'h00);
      rd(2'h1, 8'h40);
      rd(2'h2, 8'h80);
      rd(2'h3, 8'h00);
      chk(mode, icu_pkg::MODE_LOOP_ENGAGED);
      chk(loop_enabled, 1'b1);
      // loop output at full rate over one reference period
      wr(2'h1, 8'h00);
      count(6, 30000);
      count(1, 5000);
      chk(n_sys inside {[496:528]}, 1'b1);
      // all ones into every register, high address first
      for (int i = 3; i >= 0; i--) begin
         wr(2'(i), 8'hff);
         rd(2'(i), ones[i]);
      end
      chk(mode, icu_pkg::MODE_BYPASS_LOW_POWER);
      chk(loop_enabled, 1'b0);
      wait_status();
      rd(2'h3, 8'h05);
      wr(2'h1, 8'h00);
      @(posedge clk);
      #1 chk(mode, icu_pkg::MODE_LOOP_BYPASSED);
      chk(loop_enabled, 1'b1);
      // trims kept over an ordinary reset
      wr(2'h2, 8'h33);
      wr(2'h3, 8'h01);
      do_reset();
      rd(2'h2, 8'h33);
      rd(2'h3, 8'h01);
      rd(2'h1, 8'h40);
      chk(mode, icu_pkg::MODE_LOOP_ENGAGED);
      // reference period against the nine trim bits
      for (int k = 0; k < 3; k++) begin
         wr(2'h2, trims[k][8:1]);
         wr(2'h3, {7'h00, trims[k][0]});
         count(2, 5000);
         count(1, 5000);
         chk(n_cyc, icu_pkg::REF_BASE_CYCLES + trims[k]);
      end
      // divider codes on the reference source, eight source ticks each
      wr(2'h0, 8'h40);
      wait_status();
      for (int c = 0; c < 4; c++) begin
         wr(2'h1, {2'(c), 6'h00});
         count(1, 5000);
         count(8, 20000);
         chk(n_sys, 8 >> c);
         if (c < 3) chk(n_bus, 4 >> c);
      end
      // stop with and without the reference kept
      pulse(1'b0);
      chk(mode, icu_pkg::MODE_STOP);
      chk(loop_enabled, 1'b0);
      count(1000, 2000);
      chk(n_sys + n_bus + n_ref, 0);
      pulse(1'b1);
      chk(mode, icu_pkg::MODE_LOOP_BYPASSED);
      wr(2'h0, 8'h41);
      pulse(1'b0);
      count(1000, 2000);
      chk(n_sys, 0);
      chk(n_ref > 0, 1'b1);
      do_reset();
      @(posedge clk);
      #1 chk(mode, icu_pkg::MODE_LOOP_ENGAGED);
      conclude();
   end
   // watchdog only a little past the expected run
   initial begin
      #9500000;
      n_fail++;
      $display("MISMATCH %0t watchdog expired", $time);
      conclude();
   end
endmodule : tb_top
`default_nettype wire
